// ===== pkg/rsc_defs.svh
// constants for the reset source control block
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH
`define RSC_CLK_PERIOD_PS 5000
`define RSC_POWERUP_TIMER_DELAY_US 64000
`define RSC_POWERUP_TIMER_CYCLES ((`RSC_POWERUP_TIMER_DELAY_US * 1000) / (`RSC_CLK_PERIOD_PS / 1000))
`define RSC_BOR_FILTER_NS 100
`define RSC_BOR_FILTER_CYCLES ((`RSC_BOR_FILTER_NS * 1000) / `RSC_CLK_PERIOD_PS)
`define RSC_PIN_FILTER_NS 50
`define RSC_PIN_FILTER_CYCLES ((`RSC_PIN_FILTER_NS * 1000) / `RSC_CLK_PERIOD_PS)
`define RSC_ADDR_BORCTL 4'h0
`define RSC_ADDR_PWRCTL 4'h1
`define RSC_ADDR_STATUS 4'h2
`define RSC_BIT_SW_EN 7
`define RSC_BIT_FAST 6
`define RSC_BIT_READY 0
`define RSC_BIT_OVF 7
`define RSC_BIT_UNF 6
`define RSC_BIT_EXTR 3
`define RSC_BIT_RI 2
`define RSC_BIT_POR 1
`define RSC_BIT_BOR 0
`define RSC_BIT_TO 1
`define RSC_BIT_PD 0
`define RSC_MODE_ON 2'h3
`define RSC_MODE_NOSLEEP 2'h2
`define RSC_MODE_SW 2'h1
`define RSC_MODE_OFF 2'h0
`endif

// ===== pkg/rsc_pkg.sv
// types for the reset source control block
package rsc_pkg;
   typedef struct packed {
      logic [1:0] bor_mode_cfg;
      logic brownout_level_select;
      logic ext_reset_pin_enable;
      logic low_voltage_prog_enable;
      logic stack_fault_reset_enable;
      logic powerup_timer_enable_n;
   } rsc_cfg_t;
   typedef struct packed {
      logic watchdog_expire;
      logic watchdog_clear_instr;
      logic reset_instr;
      logic stack_over;
      logic stack_under;
      logic prog_exit;
      logic sleep;
      logic wake;
   } rsc_evt_t;
   typedef enum logic [1:0] {RSC_HOLD, RSC_POWERUP_TIMER, RSC_WAIT_RDY, RSC_RUN}
      rsc_state_t;
endpackage

// ===== rtl/rsc_filter.sv
// glitch filter: output follows input once stable for a cycle count
`timescale 1ns/1ps
module rsc_filter #(
   parameter int unsigned COUNT = 4,
   parameter logic INIT = 1'b0
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic raw_i,
   output logic filt_o
);
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic next_filt;

   always_comb
   begin
      next_cnt = 16'h0000;
      next_filt = filt_o;
      if (raw_i != filt_o)
      begin
         if (cnt >= 16'(COUNT))
            next_filt = raw_i;
         else
            next_cnt = cnt + 16'h0001;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         cnt <= 16'h0000;
         filt_o <= INIT;
      end
      else
      begin
         cnt <= next_cnt;
         filt_o <= next_filt;
      end
   end
endmodule

// ===== rtl/rsc_reset_ctl.sv
// reset source combiner with brown-out control and status registers
// Contract
// - two-bit field picks four brown-out modes
// - brown-out trips only after filtered long dip
// - mode 11: start waits, sleep protected, wake free
// - mode 10: off in sleep, wake waits ready
// - mode 01: software bit enables, start immediate; code waits ready while the bit is set
// - software mode protects once ready, ready visible
// - ready bit at bit zero, read only
// - software enable always stored, used in 01
// - fast start forces band-gap in 10/01
// - start waits ready per mode and enable
// - forced-on detector already ready, no delay; code still waits ready in mode 11
// - one configuration bit picks trip level
// - pin reset enabled by prog or enable bit
// - low pin holds reset, filtered, pull-up
// - pin never driven low by device
// - disabled pin is input, soft pull-up
// - watchdog expiry resets, updates timeout flags
// - reset instruction resets, clears its flag
// - stack fault resets when enabled, sets flag
// - programming exit acts as power-on reset
// - power-up timer optionally extends reset
// - timer 64 ms, enabled by cleared bit
// - timer starts after power-on and brown-out release
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_reset_ctl #(
   parameter int unsigned POWERUP_TIMER_CYCLES = `RSC_POWERUP_TIMER_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire rsc_pkg::rsc_cfg_t cfg_i,
   input wire rsc_pkg::rsc_evt_t evt_i,
   input wire logic supply_low_i,
   input wire logic detector_ready_i,
   input wire logic ext_reset_pin_i,
   input wire logic sw_pullup_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic core_reset_o,
   output logic detector_enable_o,
   output logic bandgap_force_o,
   output logic brownout_level_select_o,
   output logic ext_reset_pin_o,
   output logic ext_reset_pin_oe_o,
   output logic pin_pullup_o,
   output logic gpio_in_o
);
   localparam int unsigned BOR_FILT = (`RSC_BOR_FILTER_CYCLES < 1) ? 1 :
      `RSC_BOR_FILTER_CYCLES;
   localparam int unsigned PIN_FILT = (`RSC_PIN_FILTER_CYCLES < 1) ? 1 :
      `RSC_PIN_FILTER_CYCLES;

   // register state
   logic sw_brownout_enable;
   logic brownout_fast_start;
   logic stack_over_flag;
   logic stack_under_flag;
   logic ext_reset_flag_n;
   logic reset_instr_flag_n;
   logic por_flag_n;
   logic bor_flag_n;
   logic timeout_flag_n;
   logic powerdown_flag_n;
   logic next_sw_brownout_enable;
   logic next_brownout_fast_start;
   logic next_stack_over_flag;
   logic next_stack_under_flag;
   logic next_ext_reset_flag_n;
   logic next_reset_instr_flag_n;
   logic next_por_flag_n;
   logic next_bor_flag_n;
   logic next_timeout_flag_n;
   logic next_powerdown_flag_n;
   logic [7:0] next_rdata;

   // sequencer state
   rsc_pkg::rsc_state_t state;
   rsc_pkg::rsc_state_t next_state;
   logic [31:0] powerup_timer_cnt;
   logic [31:0] next_powerup_timer_cnt;
   logic asleep;
   logic next_asleep;
   logic power_on;
   logic next_power_on;
   logic pulse_reset;
   logic next_pulse_reset;

   logic bor_low_filt;
   logic pin_filt;
   logic pin_en;
   logic bor_active;
   logic brownout_reset;
   logic brownout_ready_flag;
   logic need_ready;

   function automatic logic mode_is(input logic [1:0] m,
                                    input logic [1:0] want);
      mode_is = (m == want);
   endfunction

   rsc_filter #(.COUNT(BOR_FILT), .INIT(1'b0)) u_bor_filt (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .raw_i(supply_low_i & bor_active),
      .filt_o(bor_low_filt)
   );

   rsc_filter #(.COUNT(PIN_FILT), .INIT(1'b1)) u_pin_filt (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .raw_i(ext_reset_pin_i),
      .filt_o(pin_filt)
   );

   always_comb
   begin
      // protection per mode
      bor_active = 1'b0;
      case (cfg_i.bor_mode_cfg)
         `RSC_MODE_ON: bor_active = 1'b1;
         `RSC_MODE_NOSLEEP: bor_active = ~asleep;
         `RSC_MODE_SW: bor_active = sw_brownout_enable;
         default: bor_active = 1'b0;
      endcase
      detector_enable_o = bor_active;
      // sw mode protects only after detector is ready
      brownout_reset = bor_low_filt & bor_active & detector_ready_i;
      brownout_ready_flag = bor_active & detector_ready_i;
      bandgap_force_o = brownout_fast_start &
         (mode_is(cfg_i.bor_mode_cfg, `RSC_MODE_NOSLEEP) |
          mode_is(cfg_i.bor_mode_cfg, `RSC_MODE_SW));
      brownout_level_select_o = cfg_i.brownout_level_select;
      // always-on mode waits for ready too, so the flag is set before
      // execution even with the timer off
      need_ready = mode_is(cfg_i.bor_mode_cfg, `RSC_MODE_ON) |
         mode_is(cfg_i.bor_mode_cfg, `RSC_MODE_NOSLEEP) |
         (mode_is(cfg_i.bor_mode_cfg, `RSC_MODE_SW) & sw_brownout_enable);
      pin_en = cfg_i.low_voltage_prog_enable |
         cfg_i.ext_reset_pin_enable;
      ext_reset_pin_o = 1'b0;
      ext_reset_pin_oe_o = 1'b0;
      pin_pullup_o = pin_en ? 1'b1 : sw_pullup_i;
      gpio_in_o = pin_en ? 1'b1 : ext_reset_pin_i;
   end

   always_comb
   begin
      next_state = state;
      next_powerup_timer_cnt = powerup_timer_cnt;
      next_asleep = asleep;
      next_power_on = power_on;
      next_pulse_reset = 1'b0;
      if (evt_i.sleep)
         next_asleep = 1'b1;
      if (evt_i.prog_exit)
         next_power_on = 1'b1;
      if ((evt_i.watchdog_expire & ~evt_i.watchdog_clear_instr) |
          evt_i.reset_instr |
          (cfg_i.stack_fault_reset_enable &
           (evt_i.stack_over | evt_i.stack_under)))
         next_pulse_reset = 1'b1;
      case (state)
         rsc_pkg::RSC_HOLD:
         begin
            // timer waits for power-on and brown-out release
            if (!power_on && !brownout_reset)
            begin
               next_powerup_timer_cnt = 32'h00000000;
               if (!cfg_i.powerup_timer_enable_n)
                  next_state = rsc_pkg::RSC_POWERUP_TIMER;
               else
                  next_state = rsc_pkg::RSC_WAIT_RDY;
            end
            next_power_on = evt_i.prog_exit;
         end
         rsc_pkg::RSC_POWERUP_TIMER:
         begin
            if (powerup_timer_cnt >= POWERUP_TIMER_CYCLES - 1)
               next_state = rsc_pkg::RSC_WAIT_RDY;
            else
               next_powerup_timer_cnt = powerup_timer_cnt + 32'h00000001;
         end
         rsc_pkg::RSC_WAIT_RDY:
         begin
            // modes 11 and 10 also need supply above threshold
            if ((!need_ready || detector_ready_i) &&
                !(cfg_i.bor_mode_cfg[1] && bor_low_filt))
               next_state = rsc_pkg::RSC_RUN;
         end
         default:
         begin
            // wake in off-in-sleep mode waits ready again
            if (evt_i.wake)
            begin
               next_asleep = 1'b0;
               if (mode_is(cfg_i.bor_mode_cfg, `RSC_MODE_NOSLEEP))
                  next_state = rsc_pkg::RSC_WAIT_RDY;
            end
         end
      endcase
      if (brownout_reset || power_on || evt_i.prog_exit)
         next_state = rsc_pkg::RSC_HOLD;
   end

   // pin hold is independent of the timer
   assign core_reset_o = (state != rsc_pkg::RSC_RUN) | pulse_reset |
      (pin_en & ~pin_filt);

   always_comb
   begin
      next_sw_brownout_enable = sw_brownout_enable;
      next_brownout_fast_start = brownout_fast_start;
      next_stack_over_flag = stack_over_flag;
      next_stack_under_flag = stack_under_flag;
      next_ext_reset_flag_n = ext_reset_flag_n;
      next_reset_instr_flag_n = reset_instr_flag_n;
      next_por_flag_n = por_flag_n;
      next_bor_flag_n = bor_flag_n;
      next_timeout_flag_n = timeout_flag_n;
      next_powerdown_flag_n = powerdown_flag_n;
      next_rdata = 8'h00;
      if (wr_i)
      begin
         if (addr_i == `RSC_ADDR_BORCTL)
         begin
            next_sw_brownout_enable = wdata_i[`RSC_BIT_SW_EN];
            next_brownout_fast_start = wdata_i[`RSC_BIT_FAST];
         end
         else if (addr_i == `RSC_ADDR_PWRCTL)
         begin
            next_stack_over_flag = wdata_i[`RSC_BIT_OVF];
            next_stack_under_flag = wdata_i[`RSC_BIT_UNF];
            next_ext_reset_flag_n = wdata_i[`RSC_BIT_EXTR];
            next_reset_instr_flag_n = wdata_i[`RSC_BIT_RI];
            next_por_flag_n = wdata_i[`RSC_BIT_POR];
            next_bor_flag_n = wdata_i[`RSC_BIT_BOR];
         end
      end
      // hardware events win over a same-cycle write
      if (evt_i.watchdog_expire & ~evt_i.watchdog_clear_instr)
      begin
         next_timeout_flag_n = 1'b0;
         next_powerdown_flag_n = ~asleep;
      end
      if (evt_i.watchdog_clear_instr)
      begin
         next_timeout_flag_n = 1'b1;
         next_powerdown_flag_n = 1'b1;
      end
      if (evt_i.reset_instr)
         next_reset_instr_flag_n = 1'b0;
      if (cfg_i.stack_fault_reset_enable & evt_i.stack_over)
         next_stack_over_flag = 1'b1;
      if (cfg_i.stack_fault_reset_enable & evt_i.stack_under)
         next_stack_under_flag = 1'b1;
      if (pin_en & ~pin_filt)
         next_ext_reset_flag_n = 1'b0;
      if (brownout_reset)
         next_bor_flag_n = 1'b0;
      if (evt_i.prog_exit)
      begin
         next_por_flag_n = 1'b0;
         next_timeout_flag_n = 1'b1;
         next_powerdown_flag_n = 1'b1;
         // every bit except bor_flag_n takes its power-on value, as after rst_i
         next_sw_brownout_enable = 1'b1;
         next_brownout_fast_start = 1'b0;
         next_stack_over_flag = 1'b0;
         next_stack_under_flag = 1'b0;
         next_ext_reset_flag_n = 1'b1;
         next_reset_instr_flag_n = 1'b1;
      end
      if (rd_i)
      begin
         if (addr_i == `RSC_ADDR_BORCTL)
         begin
            next_rdata[`RSC_BIT_SW_EN] = sw_brownout_enable;
            next_rdata[`RSC_BIT_FAST] = brownout_fast_start;
            next_rdata[`RSC_BIT_READY] = brownout_ready_flag;
         end
         else if (addr_i == `RSC_ADDR_PWRCTL)
         begin
            next_rdata[`RSC_BIT_OVF] = stack_over_flag;
            next_rdata[`RSC_BIT_UNF] = stack_under_flag;
            next_rdata[`RSC_BIT_EXTR] = ext_reset_flag_n;
            next_rdata[`RSC_BIT_RI] = reset_instr_flag_n;
            next_rdata[`RSC_BIT_POR] = por_flag_n;
            next_rdata[`RSC_BIT_BOR] = bor_flag_n;
         end
         else if (addr_i == `RSC_ADDR_STATUS)
         begin
            next_rdata[`RSC_BIT_TO] = timeout_flag_n;
            next_rdata[`RSC_BIT_PD] = powerdown_flag_n;
         end
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         // rst_i models the power-on event itself
         state <= rsc_pkg::RSC_HOLD;
         powerup_timer_cnt <= 32'h00000000;
         asleep <= 1'b0;
         power_on <= 1'b1;
         pulse_reset <= 1'b0;
         sw_brownout_enable <= 1'b1;
         brownout_fast_start <= 1'b0;
         stack_over_flag <= 1'b0;
         stack_under_flag <= 1'b0;
         ext_reset_flag_n <= 1'b1;
         reset_instr_flag_n <= 1'b1;
         por_flag_n <= 1'b0;
         bor_flag_n <= 1'b1;
         timeout_flag_n <= 1'b1;
         powerdown_flag_n <= 1'b1;
         rdata_o <= 8'h00;
      end
      else
      begin
         state <= next_state;
         powerup_timer_cnt <= next_powerup_timer_cnt;
         asleep <= next_asleep;
         power_on <= next_power_on;
         pulse_reset <= next_pulse_reset;
         sw_brownout_enable <= next_sw_brownout_enable;
         brownout_fast_start <= next_brownout_fast_start;
         stack_over_flag <= next_stack_over_flag;
         stack_under_flag <= next_stack_under_flag;
         ext_reset_flag_n <= next_ext_reset_flag_n;
         reset_instr_flag_n <= next_reset_instr_flag_n;
         por_flag_n <= next_por_flag_n;
         bor_flag_n <= next_bor_flag_n;
         timeout_flag_n <= next_timeout_flag_n;
         powerdown_flag_n <= next_powerdown_flag_n;
         rdata_o <= next_rdata;
      end
   end
endmodule

// ===== tb/rsc_far_side.sv
// far side model: reset pin driver and supply monitor
`timescale 1ns/1ps
module rsc_far_side #(
   parameter int RDY_DLY = 4
) (
   input wire logic core_clk_i,
   input wire logic det_en_i,
   input wire logic pull_up_i,
   input wire logic pin_oe_i,
   input wire logic pin_out_i,
   input wire logic pin_low_i,
   input wire logic dip_i,
   output logic pin_o,
   output logic supply_low_o,
   output logic det_ready_o
);
   int cnt = 0;
   logic tog = 1'b0;
   // analog detector needs a few cycles after enable
   always @(posedge core_clk_i)
   begin
      tog <= ~tog;
      cnt <= det_en_i ? ((cnt < RDY_DLY) ? cnt + 1 : cnt) : 0;
   end
   assign det_ready_o = (cnt == RDY_DLY);
   assign supply_low_o = dip_i;
   // without pull-up an undriven pin wanders
   assign pin_o = pin_oe_i ? pin_out_i
      : (pin_low_i ? 1'b0 : (pull_up_i ? 1'b1 : tog));
endmodule

// ===== tb/rsc_reset_ctl_properties.sv
// port assertions for the reset source control block
`timescale 1ns/1ps
module rsc_reset_ctl_properties #(
   parameter int unsigned POWERUP_TIMER_CYCLES = 20
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire rsc_pkg::rsc_cfg_t cfg_i,
   input wire rsc_pkg::rsc_evt_t evt_i,
   input wire logic supply_low_i,
   input wire logic detector_ready_i,
   input wire logic ext_reset_pin_i,
   input wire logic sw_pullup_i,
   input wire logic [3:0] addr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic core_reset_o,
   input wire logic detector_enable_o,
   input wire logic bandgap_force_o,
   input wire logic brownout_level_select_o,
   input wire logic ext_reset_pin_oe_o,
   input wire logic pin_pullup_o,
   input wire logic gpio_in_o
);
   logic pin_on;
   logic [5:0] pin_cnt, next_pin_cnt, dip_cnt, next_dip_cnt;
   logic [31:0] up_cnt, next_up_cnt;
   assign pin_on = cfg_i.ext_reset_pin_enable
      | cfg_i.low_voltage_prog_enable;
   // counters saturate so a long hold never wraps
   always_comb
   begin
      next_pin_cnt = '0;
      next_dip_cnt = '0;
      next_up_cnt = up_cnt + 32'(up_cnt < POWERUP_TIMER_CYCLES);
      if (pin_on && !ext_reset_pin_i)
         next_pin_cnt = pin_cnt + 6'(pin_cnt != 6'h3F);
      if (detector_enable_o && detector_ready_i && supply_low_i)
         next_dip_cnt = dip_cnt + 6'(dip_cnt != 6'h3F);
   end
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         {pin_cnt, dip_cnt, up_cnt} <= '0;
      else
         {pin_cnt, dip_cnt, up_cnt} <=
            {next_pin_cnt, next_dip_cnt, next_up_cnt};
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   pin_undriven_a: assert property (!ext_reset_pin_oe_o)
      else $error("reset pin output enabled");
   level_copy_a: assert property (
      brownout_level_select_o == cfg_i.brownout_level_select)
      else $error("trip level not from config");
   fast_inert_a: assert property (
      cfg_i.bor_mode_cfg[1] == cfg_i.bor_mode_cfg[0] |-> !bandgap_force_o)
      else $error("band-gap forced in mode 11 or 00");
   mode_off_a: assert property (
      cfg_i.bor_mode_cfg == 2'h0 |-> !detector_enable_o)
      else $error("detector on in mode 00");
   pullup_sel_a: assert property (
      pin_pullup_o == (pin_on | sw_pullup_i))
      else $error("pull-up selection wrong");
   rst_instr_a: assert property (
      evt_i.reset_instr |=> core_reset_o)
      else $error("reset instruction ignored");
   stack_fault_a: assert property (
      evt_i.stack_over && cfg_i.stack_fault_reset_enable |=> core_reset_o)
      else $error("stack fault ignored");
   pin_hold_a: assert property (pin_cnt > 6'h10 |-> core_reset_o)
      else $error("low pin not holding reset");
   dip_trip_a: assert property (dip_cnt > 6'h1A |-> core_reset_o)
      else $error("long dip not resetting");
   timer_hold_a: assert property (
      !cfg_i.powerup_timer_enable_n && up_cnt < POWERUP_TIMER_CYCLES |-> core_reset_o)
      else $error("released before timer ran out");
   ready_bit_a: assert property (
      $past(rd_i && addr_i == 4'h0) |-> rdata_o[5:0] ==
      {5'h00, $past(detector_enable_o & detector_ready_i)})
      else $error("ready bit wrong");
   cover property (evt_i.reset_instr);
   cover property (pin_cnt > 6'h10);
   cover property (dip_cnt > 6'h1A);
endmodule

// ===== tb/rsc_reset_ctl_tb_top.sv
// bench for the reset source control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; \
   if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module rsc_reset_ctl_tb_top;
   localparam int unsigned POWERUP_TIMER = 20;
   logic core_clk_i, rst_i, wr, rd, sw_pu, pin_low, dip;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   rsc_pkg::rsc_cfg_t cfg;
   rsc_pkg::rsc_evt_t evt;
   logic sup_low, det_rdy, pin, core_reset, det_en, bg, lvl;
   logic pin_o, pin_oe, pull, gpio;
   int bad_count = 0, samples_checked = 0, n;
   rsc_pkg::rsc_evt_t et [4] = '{8'h20, 8'h80, 8'h10, 8'h08};
   logic [3:0] ea [4] = '{4'h1, 4'h2, 4'h1, 4'h1};
   logic [7:0] em [4] = '{8'h04, 8'h02, 8'h80, 8'h40};
   logic [7:0] ev [4] = '{8'h00, 8'h00, 8'h80, 8'h40};
   rsc_reset_ctl #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER)) u_rsc_reset_ctl (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .cfg_i(cfg), .evt_i(evt),
      .supply_low_i(sup_low), .detector_ready_i(det_rdy),
      .ext_reset_pin_i(pin), .sw_pullup_i(sw_pu), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .core_reset_o(core_reset), .detector_enable_o(det_en),
      .bandgap_force_o(bg), .brownout_level_select_o(lvl),
      .ext_reset_pin_o(pin_o), .ext_reset_pin_oe_o(pin_oe),
      .pin_pullup_o(pull), .gpio_in_o(gpio));
   rsc_far_side u_rsc_far_side (.core_clk_i(core_clk_i),
      .det_en_i(det_en), .pull_up_i(pull), .pin_oe_i(pin_oe),
      .pin_out_i(pin_o), .pin_low_i(pin_low), .dip_i(dip),
      .pin_o(pin), .supply_low_o(sup_low), .det_ready_o(det_rdy));
   task automatic close_out();
      $display("mismatches %0d checks %0d", bad_count, samples_checked);
      if (bad_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one register access; a read compares the masked answer with d
   task automatic acc(input bit w, input logic [3:0] a,
      input logic [7:0] d, m);
      @(posedge core_clk_i);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge core_clk_i);
      {wr, rd} <= 2'b00;
      #1;
      if (!w)
         `CHK("rdata", d, rdata & m)
   endtask
   task automatic pulse(input rsc_pkg::rsc_evt_t e);
      @(posedge core_clk_i);
      evt <= e;
      @(posedge core_clk_i);
      evt <= '0;
      #1;
   endtask
   task automatic wait_run();
      n = 0;
      while (core_reset !== 1'b0)
      begin
         @(posedge core_clk_i);
         #1;
         n++;
         if (n > 500)
         begin
            `CHK("release", 1'b0, core_reset)
            close_out();
         end
      end
   endtask
   task automatic low_for(input bit p, input int c, input logic e);
      @(posedge core_clk_i);
      pin_low <= p;
      dip <= !p;
      repeat (c) @(posedge core_clk_i);
      #1;
      `CHK("held", e, core_reset)
      @(posedge core_clk_i);
      {pin_low, dip} <= 2'b00;
      wait_run();
   endtask
   initial
   begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   initial
   begin
      rst_i = 1'b1;
      {wr, rd, sw_pu, pin_low, dip, addr, wdata, evt} = '0;
      // mode 11, pin reset on, stack reset on, timer on
      cfg = 7'h6A;
      repeat (8) @(posedge core_clk_i);
      rst_i <= 1'b0;
      wait_run();
      `CHK("timer", 1'b1, n >= POWERUP_TIMER)
      acc(0, 4'h0, 8'h81, 8'hFF);
      acc(0, 4'h1, 8'h0C, 8'hFE);
      acc(0, 4'h2, 8'h03, 8'h03);
      acc(1, 4'hF, 8'hFF, 8'h00);
      acc(0, 4'hF, 8'h00, 8'hFF);
      acc(1, 4'h0, 8'h01, 8'h00);
      acc(0, 4'h0, 8'h01, 8'hFF);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge core_clk_i);
         cfg.bor_mode_cfg <= i[2:1];
         cfg.brownout_level_select <= i[0];
         acc(1, 4'h0, {i[0], 7'h40}, 8'h00);
         `CHK("enable", i[2] | (i[1] & i[0]), det_en)
         `CHK("force", i[2] ^ i[1], bg)
         `CHK("level", i[0], lvl)
         acc(0, 4'h0, {i[0], 7'h40}, 8'hC0);
      end
      @(posedge core_clk_i);
      cfg.bor_mode_cfg <= 2'h2;
      pulse(8'h02);
      `CHK("sleep off", 1'b0, det_en)
      pulse(8'h01);
      `CHK("wake wait", 1'b1, core_reset)
      wait_run();
      @(posedge core_clk_i);
      cfg.bor_mode_cfg <= 2'h3;
      pulse(8'h02);
      `CHK("sleep on", 1'b1, det_en)
      pulse(8'h01);
      `CHK("wake free", 1'b0, core_reset)
      for (int i = 0; i < 4; i++)
      begin
         pulse(et[i]);
         `CHK("event", 1'b1, core_reset)
         wait_run();
         acc(0, ea[i], ev[i], em[i]);
      end
      @(posedge core_clk_i);
      cfg.stack_fault_reset_enable <= 1'b0;
      pulse(8'h10);
      `CHK("stack off", 1'b0, core_reset)
      pulse(8'hC0);
      `CHK("wdt cleared", 1'b0, core_reset)
      low_for(1'b0, 10, 1'b0);
      low_for(1'b0, 40, 1'b1);
      low_for(1'b1, 4, 1'b0);
      low_for(1'b1, 30, 1'b1);
      `CHK("pin drive", 2'b00, {pin_oe, pin_o})
      @(posedge core_clk_i);
      cfg.bor_mode_cfg <= 2'h1;
      acc(1, 4'h0, 8'h00, 8'h00);
      low_for(1'b0, 40, 1'b0);
      @(posedge core_clk_i);
      cfg.ext_reset_pin_enable <= 1'b0;
      low_for(1'b1, 30, 1'b0);
      @(posedge core_clk_i);
      pin_low <= 1'b1;
      sw_pu <= 1'b1;
      #1;
      `CHK("gpio", 1'b0, gpio)
      `CHK("soft pull", 1'b1, pull)
      @(posedge core_clk_i);
      cfg.low_voltage_prog_enable <= 1'b1;
      {pin_low, sw_pu} <= 2'b00;
      #1;
      `CHK("prog pull", 1'b1, pull)
      pulse(8'h04);
      wait_run();
      `CHK("prog exit", 1'b1, n >= POWERUP_TIMER)
      acc(0, 4'h0, 8'h80, 8'hC0);
      acc(0, 4'h1, 8'h04, 8'hF6);
      close_out();
   end
endmodule
bind rsc_reset_ctl rsc_reset_ctl_properties #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES))
   u_rsc_reset_ctl_properties (.*);
